// ### logic/cie_exec.sv
// Purpose: executes the skip, table read, exclusive-OR and far-access instructions
// Assumes: data and program memory answer combinationally within the cycle
// Notes: one instruction taken per idle cycle; busy while a sequence runs
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Zero-test load copies byte to accumulator; skips next when byte is zero.
// [RULE2] Bit test skips next instruction when selected bit is zero; no flags.
// [RULE3] Taken skip adds one dummy cycle, two instruction cycles in total.
// [RULE4] Paged table read uses high and low pointer; low to memory, high latched.
// [RULE5] Last-page table read uses final page and pointer low byte only.
// [RULE6] Pre-increment paged read bumps pointer low byte first, then reads.
// [RULE7] Pre-increment last-page read bumps pointer low byte, then reads last page.
// [RULE8] Exclusive-OR with byte or immediate into accumulator or memory; zero flag only.
// [RULE9] Far forms reach any data memory section with a full address.
// [RULE10] Add with carry sums accumulator, byte, carry; five arithmetic flags update.
// [RULE11] Add without carry sums accumulator and byte; five arithmetic flags update.
// [RULE12] AND of accumulator and byte into chosen target; zero flag only.
// [RULE13] Clear writes zero to byte or one bit; flags unchanged.
// [RULE14] Complement inverts byte into memory or accumulator; zero flag updates.
// [RULE15] Decimal adjust adds six per nibble over nine or with carry; result to memory.
// [RULE16] Decimal adjust touches only carry, set when decimal sum exceeds one hundred; the code also sets it at exactly one hundred.
// [RULE17] Decrement subtracts one into memory or accumulator; zero flag updates.
// [RULE18] Increment adds one into memory or accumulator; zero flag updates.
// [RULE19] Move copies between byte and accumulator; flags unchanged.
// [RULE20] OR of accumulator and byte goes into the accumulator.
// [RULE21] Accumulator-target forms never write the source data byte.
// [RULE22] Overflow, half-carry and signed-carry follow usual 8-bit conventions.
module cie_exec
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_valid,
    input wire cie_pkg::cie_instr_t i_instr,
    input wire logic [7:0] i_dmem_rdata,
    input wire logic [15:0] i_pmem_rdata,
    input wire logic i_tbl_ptr_we,
    input wire logic [7:0] i_tbl_ptr_low,
    input wire logic [7:0] i_tbl_ptr_high,
    output logic o_busy,
    output logic o_skip,
    output logic o_dummy_cycle,
    output logic [15:0] o_dmem_addr,
    output logic o_dmem_we,
    output logic [7:0] o_dmem_wdata,
    output logic [15:0] o_pmem_addr,
    output logic [7:0] o_acc,
    output logic [4:0] o_flags,
    output logic [7:0] o_table_pointer_low,
    output logic [7:0] o_table_pointer_high,
    output logic [7:0] o_table_high_latch
);
    typedef enum logic [1:0] {ST_IDLE, ST_TBL_FETCH, ST_DUMMY} cie_state_t;

    typedef struct packed {
        cie_state_t st;
        logic [15:0] dmem_addr;
        logic dmem_we;
        logic [7:0] dmem_wdata;
        logic [15:0] pmem_addr;
        logic busy;
        logic skip;
        logic dummy;
        logic [7:0] acc;
        logic [4:0] flags;
        logic [7:0] ptr_low;
        logic [7:0] ptr_high;
        logic [7:0] high_latch;
    } cie_exec_state_t;

    cie_exec_state_t cur;
    cie_exec_state_t next_cur;
    cie_pkg::cie_alu_out_t alu_res;
    logic [7:0] alu_opnd;
    logic [15:0] tbl_addr;
    logic [7:0] ptr_low_eff;
    logic tbl_last;
    logic tbl_inc;
    cie_pkg::cie_op_t op;

    assign op = i_instr.op;
    assign alu_opnd = (op == cie_pkg::OP_XOR_IMM) ? i_instr.imm : i_dmem_rdata;
    assign tbl_last = (op == cie_pkg::OP_TBL_LAST || op == cie_pkg::OP_TBL_LAST_INC);
    assign tbl_inc = (op == cie_pkg::OP_TBL_PAGED_INC || op == cie_pkg::OP_TBL_LAST_INC);
    assign ptr_low_eff = tbl_inc ? cur.ptr_low + cie_pkg::ONE_BYTE : cur.ptr_low; // RULE6 RULE7

    cie_alu u_alu
    (
        .i_op(op),
        .i_acc(cur.acc),
        .i_opnd(alu_opnd),
        .i_flags(cur.flags),
        .o_res(alu_res)
    );

    cie_tbl_addr u_tbl_addr
    (
        .i_last_page(tbl_last),
        .i_ptr_high(cur.ptr_high),
        .i_ptr_low(ptr_low_eff),
        .o_paddr(tbl_addr)
    );

    always_comb
    begin
        next_cur = cur;
        next_cur.dmem_we = 1'b0;
        next_cur.skip = 1'b0;
        next_cur.dummy = 1'b0;
        next_cur.dmem_addr = i_instr.addr; // RULE9
        unique case (cur.st)
            ST_IDLE:
            begin
                next_cur.busy = 1'b0;
                if (i_tbl_ptr_we)
                begin
                    next_cur.ptr_low = i_tbl_ptr_low;
                    next_cur.ptr_high = i_tbl_ptr_high;
                end
                if (i_valid)
                begin
                    unique case (op)
                        cie_pkg::OP_SKIP_ZERO_LOAD:
                        begin
                            next_cur.acc = i_dmem_rdata; // RULE1
                            if (i_dmem_rdata == cie_pkg::ZERO_BYTE) // RULE1
                            begin
                                next_cur.skip = 1'b1;
                                next_cur.busy = 1'b1;
                                next_cur.st = ST_DUMMY; // RULE3
                            end
                        end
                        cie_pkg::OP_SKIP_BIT_CLEAR:
                        begin
                            if (!i_dmem_rdata[i_instr.bit_sel]) // RULE2
                            begin
                                next_cur.skip = 1'b1;
                                next_cur.busy = 1'b1;
                                next_cur.st = ST_DUMMY; // RULE3
                            end
                        end
                        cie_pkg::OP_TBL_PAGED, cie_pkg::OP_TBL_LAST,
                        cie_pkg::OP_TBL_PAGED_INC, cie_pkg::OP_TBL_LAST_INC:
                        begin
                            next_cur.ptr_low = ptr_low_eff; // RULE6 RULE7
                            next_cur.pmem_addr = tbl_addr; // RULE4 RULE5
                            next_cur.busy = 1'b1;
                            next_cur.st = ST_TBL_FETCH;
                        end
                        cie_pkg::OP_XOR_ACC, cie_pkg::OP_XOR_IMM, cie_pkg::OP_ADC_ACC,
                        cie_pkg::OP_ADD_ACC, cie_pkg::OP_AND_ACC, cie_pkg::OP_OR_ACC,
                        cie_pkg::OP_CPL_ACC, cie_pkg::OP_DEC_ACC, cie_pkg::OP_INC_ACC:
                        begin
                            next_cur.acc = alu_res.result; // RULE21
                            next_cur.flags = alu_res.flags; // RULE8 RULE10 RULE11 RULE12
                        end
                        cie_pkg::OP_XOR_MEM, cie_pkg::OP_ADC_MEM, cie_pkg::OP_ADD_MEM,
                        cie_pkg::OP_AND_MEM, cie_pkg::OP_CPL, cie_pkg::OP_DEC,
                        cie_pkg::OP_INC, cie_pkg::OP_DAA:
                        begin
                            next_cur.dmem_we = 1'b1;
                            next_cur.dmem_wdata = alu_res.result; // RULE14 RULE15
                            next_cur.flags = alu_res.flags; // RULE16 RULE17 RULE18
                        end
                        cie_pkg::OP_CLR:
                        begin
                            next_cur.dmem_we = 1'b1;
                            next_cur.dmem_wdata = cie_pkg::ZERO_BYTE; // RULE13
                        end
                        cie_pkg::OP_CLR_BIT:
                        begin
                            next_cur.dmem_we = 1'b1;
                            next_cur.dmem_wdata = i_dmem_rdata
                                & ~(cie_pkg::ONE_BYTE << i_instr.bit_sel); // RULE13
                        end
                        cie_pkg::OP_MOV_TO_ACC:
                        begin
                            next_cur.acc = i_dmem_rdata; // RULE19
                        end
                        cie_pkg::OP_MOV_TO_MEM:
                        begin
                            next_cur.dmem_we = 1'b1;
                            next_cur.dmem_wdata = cur.acc; // RULE19
                        end
                        default:
                        begin
                            next_cur.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_TBL_FETCH:
            begin
                // Data address held from the taking cycle
                next_cur.dmem_addr = cur.dmem_addr;
                next_cur.dmem_we = 1'b1;
                next_cur.dmem_wdata = i_pmem_rdata[7:0]; // RULE4 RULE5
                next_cur.high_latch = i_pmem_rdata[15:8]; // RULE4 RULE5
                next_cur.busy = 1'b0;
                next_cur.st = ST_IDLE;
            end
            ST_DUMMY:
            begin
                next_cur.dummy = 1'b1; // RULE3
                next_cur.busy = 1'b0;
                next_cur.st = ST_IDLE;
            end
            default:
            begin
                next_cur.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            cur <= '0;
            cur.st <= ST_IDLE;
            cur.acc <= cie_pkg::ACC_RST;
            cur.flags <= cie_pkg::FLG_RST;
            cur.ptr_low <= cie_pkg::TBL_RST;
            cur.ptr_high <= cie_pkg::TBL_RST;
            cur.high_latch <= cie_pkg::TBL_RST;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign o_busy = cur.busy;
    assign o_skip = cur.skip;
    assign o_dummy_cycle = cur.dummy;
    assign o_dmem_addr = cur.dmem_addr;
    assign o_dmem_we = cur.dmem_we;
    assign o_dmem_wdata = cur.dmem_wdata;
    assign o_pmem_addr = cur.pmem_addr;
    assign o_acc = cur.acc;
    assign o_flags = cur.flags;
    assign o_table_pointer_low = cur.ptr_low;
    assign o_table_pointer_high = cur.ptr_high;
    assign o_table_high_latch = cur.high_latch;

    a_skip_dummy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        o_skip |=> o_dummy_cycle && !o_busy) // RULE3
        else $error("skip not followed by one dummy cycle");
    a_szl_load: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!o_busy && i_valid && op == cie_pkg::OP_SKIP_ZERO_LOAD)
        |=> o_acc == $past(i_dmem_rdata) && o_skip == ($past(i_dmem_rdata) == 8'h00)) // RULE1
        else $error("zero-test load wrong");
    a_bit_skip: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!o_busy && i_valid && op == cie_pkg::OP_SKIP_BIT_CLEAR)
        |=> o_skip == !$past(i_dmem_rdata[i_instr.bit_sel]) && $stable(o_flags)) // RULE2
        else $error("bit test skip wrong");
    a_tbl_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!o_busy && i_valid && tbl_last)
        |=> o_pmem_addr[15:8] == 8'hFF ##1 o_dmem_we) // RULE5
        else $error("last page table read wrong");
    a_tbl_preinc: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!o_busy && i_valid && tbl_inc)
        |=> o_table_pointer_low == $past(o_table_pointer_low) + 8'h01) // RULE6
        else $error("pointer not pre-incremented");
    a_acc_no_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!o_busy && i_valid && (op == cie_pkg::OP_ADD_ACC || op == cie_pkg::OP_INC_ACC
        || op == cie_pkg::OP_XOR_ACC)) |=> !o_dmem_we) // RULE21
        else $error("accumulator form wrote memory");
    a_clr_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!o_busy && i_valid && op == cie_pkg::OP_CLR)
        |=> o_dmem_we && o_dmem_wdata == 8'h00 && $stable(o_flags)) // RULE13
        else $error("clear wrong");
    a_mov_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!o_busy && i_valid && op == cie_pkg::OP_MOV_TO_MEM)
        |=> o_dmem_wdata == $past(o_acc) && $stable(o_flags)) // RULE19
        else $error("move wrong");
    a_add_sum: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!o_busy && i_valid && op == cie_pkg::OP_ADD_ACC)
        |=> o_acc == 8'($past(o_acc) + $past(i_dmem_rdata))) // RULE11
        else $error("add result wrong");
    c_skip: cover property (@(posedge i_clk) o_skip ##1 o_dummy_cycle);
    c_tbl: cover property (@(posedge i_clk) o_busy && !o_skip ##1 o_dmem_we);
    c_mem_write: cover property (@(posedge i_clk) o_dmem_we && !o_busy);
endmodule // cie_exec

// ### pkg/cie_pkg.sv
// Purpose: shared types and constants for the instruction execute subset
// Assumes: 8-bit data path, 16-bit program words, 100 MHz core clock
// Notes: opcodes are a local encoding of the operations handled here
package cie_pkg;
    localparam int DATA_W = 8;
    localparam int DADDR_W = 16;
    localparam int PADDR_W = 16;
    localparam int PWORD_W = 16;
    localparam logic [7:0] LAST_PAGE = 8'hFF;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] TBL_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam logic [3:0] STEP_LIMIT = 4'hF;
    // Flag vector bit positions
    localparam int FLG_C = 0;
    localparam int FLG_AC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam int FLG_SC = 4;
    localparam logic [4:0] FLG_RST = 5'h00;

    typedef enum logic [4:0] {
        OP_NOP, OP_SKIP_ZERO_LOAD, OP_SKIP_BIT_CLEAR,
        OP_TBL_PAGED, OP_TBL_LAST, OP_TBL_PAGED_INC, OP_TBL_LAST_INC,
        OP_XOR_ACC, OP_XOR_MEM, OP_XOR_IMM,
        OP_ADC_ACC, OP_ADC_MEM, OP_ADD_ACC, OP_ADD_MEM,
        OP_AND_ACC, OP_AND_MEM, OP_CLR, OP_CLR_BIT,
        OP_CPL, OP_CPL_ACC, OP_DAA, OP_DEC, OP_DEC_ACC,
        OP_INC, OP_INC_ACC, OP_MOV_TO_ACC, OP_MOV_TO_MEM, OP_OR_ACC
    } cie_op_t;

    typedef struct packed {
        cie_op_t op;
        logic [DADDR_W-1:0] addr;
        logic [2:0] bit_sel;
        logic [DATA_W-1:0] imm;
    } cie_instr_t;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        logic [4:0] flags;
    } cie_alu_out_t;
endpackage

// ### logic/cie_alu.sv
// Purpose: combinational result and flag logic for the arithmetic and logic forms
// Assumes: inputs stable for the cycle; flags ordered as in the package
// Notes: flags not touched by an operation are passed through unchanged
`timescale 1ns/1ps
module cie_alu
(
    input wire cie_pkg::cie_op_t i_op,
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_opnd,
    input wire logic [4:0] i_flags,
    output cie_pkg::cie_alu_out_t o_res
);
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic cin;
    logic [7:0] adj;
    logic [8:0] daa_sum;

    always_comb
    begin
        cin = (i_op == cie_pkg::OP_ADC_ACC || i_op == cie_pkg::OP_ADC_MEM)
            ? i_flags[cie_pkg::FLG_C] : 1'b0;
        sum = {1'b0, i_acc} + {1'b0, i_opnd} + {8'h00, cin};
        low_sum = {1'b0, i_acc[3:0]} + {1'b0, i_opnd[3:0]} + {4'h0, cin};
        adj = cie_pkg::ZERO_BYTE;
        if (i_acc[3:0] > cie_pkg::BCD_LIMIT || i_flags[cie_pkg::FLG_AC]) // RULE15
            adj[3:0] = cie_pkg::BCD_FIX;
        if (i_acc[7:4] > cie_pkg::BCD_LIMIT || i_flags[cie_pkg::FLG_C]) // RULE15
            adj[7:4] = cie_pkg::BCD_FIX;
        daa_sum = {1'b0, i_acc} + {1'b0, adj};
        o_res.flags = i_flags;
        o_res.result = i_acc;
        unique case (i_op)
            cie_pkg::OP_ADC_ACC, cie_pkg::OP_ADC_MEM,
            cie_pkg::OP_ADD_ACC, cie_pkg::OP_ADD_MEM:
            begin
                o_res.result = sum[7:0]; // RULE10 RULE11
                o_res.flags[cie_pkg::FLG_C] = sum[8]; // RULE22
                o_res.flags[cie_pkg::FLG_AC] = low_sum[4]; // RULE22
                o_res.flags[cie_pkg::FLG_Z] = (sum[7:0] == cie_pkg::ZERO_BYTE);
                o_res.flags[cie_pkg::FLG_OV] = (i_acc[7] == i_opnd[7])
                    && (sum[7] != i_acc[7]); // RULE22
                // Signed-carry: true sign of the 9-bit signed sum
                o_res.flags[cie_pkg::FLG_SC] = sum[7] ^ ((i_acc[7] == i_opnd[7])
                    && (sum[7] != i_acc[7])); // RULE22
            end
            cie_pkg::OP_XOR_ACC, cie_pkg::OP_XOR_MEM, cie_pkg::OP_XOR_IMM:
            begin
                o_res.result = i_acc ^ i_opnd; // RULE8
                o_res.flags[cie_pkg::FLG_Z] = ((i_acc ^ i_opnd) == cie_pkg::ZERO_BYTE);
            end
            cie_pkg::OP_AND_ACC, cie_pkg::OP_AND_MEM:
            begin
                o_res.result = i_acc & i_opnd; // RULE12
                o_res.flags[cie_pkg::FLG_Z] = ((i_acc & i_opnd) == cie_pkg::ZERO_BYTE);
            end
            cie_pkg::OP_OR_ACC:
            begin
                o_res.result = i_acc | i_opnd; // RULE20
                o_res.flags[cie_pkg::FLG_Z] = ((i_acc | i_opnd) == cie_pkg::ZERO_BYTE);
            end
            cie_pkg::OP_CPL, cie_pkg::OP_CPL_ACC:
            begin
                o_res.result = ~i_opnd; // RULE14
                o_res.flags[cie_pkg::FLG_Z] = (~i_opnd == cie_pkg::ZERO_BYTE);
            end
            cie_pkg::OP_DEC, cie_pkg::OP_DEC_ACC:
            begin
                o_res.result = i_opnd - cie_pkg::ONE_BYTE; // RULE17
                o_res.flags[cie_pkg::FLG_Z] = (i_opnd == cie_pkg::ONE_BYTE);
            end
            cie_pkg::OP_INC, cie_pkg::OP_INC_ACC:
            begin
                o_res.result = i_opnd + cie_pkg::ONE_BYTE; // RULE18
                o_res.flags[cie_pkg::FLG_Z] = (i_opnd == 8'hFF);
            end
            cie_pkg::OP_DAA:
            begin
                o_res.result = daa_sum[7:0]; // RULE15
                // Carry only ever set here so a chained decimal add keeps its carry
                o_res.flags[cie_pkg::FLG_C] = i_flags[cie_pkg::FLG_C] | daa_sum[8]; // RULE16
            end
            default:
            begin
                o_res.result = i_opnd;
            end
        endcase
    end
endmodule // cie_alu

// ### logic/cie_tbl_addr.sv
// Purpose: program memory address for the four table read forms
// Assumes: pointer low byte already incremented for the pre-increment forms
// Notes: last-page reads ignore the pointer high byte
`timescale 1ns/1ps
module cie_tbl_addr
(
    input wire logic i_last_page,
    input wire logic [7:0] i_ptr_high,
    input wire logic [7:0] i_ptr_low,
    output logic [15:0] o_paddr
);
    always_comb
    begin
        if (i_last_page)
            o_paddr = {cie_pkg::LAST_PAGE, i_ptr_low}; // RULE5 RULE7
        else
            o_paddr = {i_ptr_high, i_ptr_low}; // RULE4 RULE6
    end
endmodule // cie_tbl_addr

// ### tb/cie_mem_model.sv
// Purpose: data and program memory on the far side of the execute block
// Assumes: reads answer within the cycle, writes land at the rising edge
// Notes: program words are derived from their address so any fetch can be predicted
`timescale 1ns/1ps
module cie_mem_model
(
    input wire logic i_clk,
    input wire logic i_rd_en,
    input wire logic [15:0] i_raddr,
    output logic [7:0] o_rdata,
    input wire logic i_we,
    input wire logic [15:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [15:0] i_paddr,
    output logic [15:0] o_pdata
);
    logic [7:0] mem [0:65535] = '{default: 8'h00};
    logic [7:0] last = 8'h00;
    // Idle read lines show the inverse of the last byte, never a stale copy
    assign o_rdata = i_rd_en ? mem[i_raddr] : ~last;
    assign o_pdata = {i_paddr[7:0] ^ 8'hA5, i_paddr[15:8] ^ 8'h3C};
    always @(posedge i_clk)
    begin
        if (i_rd_en)
            last <= mem[i_raddr];
        if (i_we)
            mem[i_waddr] <= i_wdata;
    end
endmodule // cie_mem_model

// ### tb/tb_top.sv
// Purpose: self-checking bench for the instruction execute subset
// Assumes: memory model answers data reads in the cycle of the request
// Notes: inputs change on the falling edge; expected state tracked in e_acc and e_flg
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    cie_pkg::cie_instr_t instr = '0;
    logic ptr_we = 1'b0;
    logic [7:0] ptr_lo = 8'h00;
    logic [7:0] ptr_hi = 8'h00;
    logic [7:0] dm_rd, dm_wd, acc, tpl, tph, tbh, e_acc, e_tp;
    logic [15:0] pm_rd, dm_a, pm_a;
    logic [4:0] flags, e_flg;
    logic busy, skip, dummy, dm_we;
    int err_count = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    cie_exec u_dut (.i_clk(clk), .i_sys_rst(rst), .i_valid(valid), .i_instr(instr),
        .i_dmem_rdata(dm_rd), .i_pmem_rdata(pm_rd), .i_tbl_ptr_we(ptr_we),
        .i_tbl_ptr_low(ptr_lo), .i_tbl_ptr_high(ptr_hi), .o_busy(busy), .o_skip(skip),
        .o_dummy_cycle(dummy), .o_dmem_addr(dm_a), .o_dmem_we(dm_we), .o_dmem_wdata(dm_wd),
        .o_pmem_addr(pm_a), .o_acc(acc), .o_flags(flags), .o_table_pointer_low(tpl),
        .o_table_pointer_high(tph), .o_table_high_latch(tbh));
    cie_mem_model u_mem (.i_clk(clk), .i_rd_en(valid), .i_raddr(instr.addr), .o_rdata(dm_rd),
        .i_we(dm_we), .i_waddr(dm_a), .i_wdata(dm_wd), .i_paddr(pm_a), .o_pdata(pm_rd));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        num_checks++;
        if (act !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, act, exp);
        end
    endtask
    // Returns at the falling edge after the instruction was taken
    task automatic issue(input cie_pkg::cie_op_t op, input logic [15:0] a, input logic [2:0] b,
        input logic [7:0] x);
        @(negedge clk);
        valid = 1'b1;
        instr = '{op, a, b, x};
        @(negedge clk);
        valid = 1'b0;
    endtask
    task automatic alu(input cie_pkg::cie_op_t op, input logic [15:0] a, input logic [2:0] b,
        input logic [7:0] x);
        logic [7:0] m;
        logic [7:0] r;
        logic [8:0] s;
        logic [4:0] h;
        logic cin;
        logic ar;
        logic to_acc;
        m = u_mem.mem[a];
        ar = op inside {cie_pkg::OP_ADC_ACC, cie_pkg::OP_ADC_MEM, cie_pkg::OP_ADD_ACC,
            cie_pkg::OP_ADD_MEM};
        cin = (op inside {cie_pkg::OP_ADC_ACC, cie_pkg::OP_ADC_MEM}) ? e_flg[0] : 1'b0;
        s = {1'b0, e_acc} + {1'b0, m} + {8'h00, cin};
        h = {1'b0, e_acc[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
        to_acc = op inside {cie_pkg::OP_XOR_ACC, cie_pkg::OP_XOR_IMM, cie_pkg::OP_ADC_ACC,
            cie_pkg::OP_ADD_ACC, cie_pkg::OP_AND_ACC, cie_pkg::OP_CPL_ACC, cie_pkg::OP_DEC_ACC,
            cie_pkg::OP_INC_ACC, cie_pkg::OP_MOV_TO_ACC, cie_pkg::OP_OR_ACC};
        case (op)
            cie_pkg::OP_XOR_ACC, cie_pkg::OP_XOR_MEM: r = e_acc ^ m;
            cie_pkg::OP_XOR_IMM: r = e_acc ^ x;
            cie_pkg::OP_AND_ACC, cie_pkg::OP_AND_MEM: r = e_acc & m;
            cie_pkg::OP_OR_ACC: r = e_acc | m;
            cie_pkg::OP_CPL, cie_pkg::OP_CPL_ACC: r = ~m;
            cie_pkg::OP_DEC, cie_pkg::OP_DEC_ACC: r = m - 8'h01;
            cie_pkg::OP_INC, cie_pkg::OP_INC_ACC: r = m + 8'h01;
            cie_pkg::OP_MOV_TO_ACC: r = m;
            cie_pkg::OP_MOV_TO_MEM: r = e_acc;
            cie_pkg::OP_CLR: r = 8'h00;
            cie_pkg::OP_CLR_BIT: r = m & ~(8'h01 << b);
            cie_pkg::OP_DAA: r = e_acc + {(e_acc[7:4] > 4'h9 || e_flg[0]) ? 4'h6 : 4'h0,
                (e_acc[3:0] > 4'h9 || e_flg[1]) ? 4'h6 : 4'h0};
            default: r = s[7:0];
        endcase
        if (ar)
            e_flg = {e_acc[7] ^ m[7] ^ s[8], e_acc[7] == m[7] && r[7] != m[7], 1'b0, h[4], s[8]};
        if (op == cie_pkg::OP_DAA && (e_acc[7:4] > 4'h9 || e_flg[0]))
            e_flg[0] = 1'b1;
        if (!(op inside {cie_pkg::OP_CLR, cie_pkg::OP_CLR_BIT, cie_pkg::OP_MOV_TO_ACC,
            cie_pkg::OP_MOV_TO_MEM, cie_pkg::OP_DAA}))
            e_flg[2] = (r == 8'h00);
        issue(op, a, b, x);
        if (to_acc)
            e_acc = r;
        chk(acc, e_acc);
        chk(flags, e_flg);
        @(negedge clk);
        chk(u_mem.mem[a], to_acc ? m : r);
    endtask
    task automatic t_reset;
        chk({acc, tph, tpl, tbh}, {cie_pkg::ACC_RST, 16'h0000, cie_pkg::TBL_RST});
        chk({flags, busy, skip, dummy, dm_we}, {cie_pkg::FLG_RST, 4'h0});
        $display("reset test done");
    endtask
    task automatic t_arith;
        u_mem.mem[16'hF123] = 8'h7F;
        u_mem.mem[16'h0010] = 8'h01;
        u_mem.mem[16'h8421] = 8'h90;
        alu(cie_pkg::OP_MOV_TO_ACC, 16'hF123, 3'h0, 8'h00);
        alu(cie_pkg::OP_ADD_ACC, 16'h0010, 3'h0, 8'h00);
        alu(cie_pkg::OP_ADD_MEM, 16'h8421, 3'h0, 8'h00);
        alu(cie_pkg::OP_ADC_ACC, 16'h0010, 3'h0, 8'h00);
        alu(cie_pkg::OP_ADC_MEM, 16'hF123, 3'h0, 8'h00);
        $display("arithmetic test done");
    endtask
    task automatic t_logic;
        cie_pkg::cie_op_t ops [15] = '{cie_pkg::OP_XOR_ACC, cie_pkg::OP_XOR_MEM,
            cie_pkg::OP_XOR_IMM, cie_pkg::OP_AND_ACC, cie_pkg::OP_AND_MEM, cie_pkg::OP_OR_ACC,
            cie_pkg::OP_CPL, cie_pkg::OP_CPL_ACC, cie_pkg::OP_DEC, cie_pkg::OP_DEC_ACC,
            cie_pkg::OP_INC, cie_pkg::OP_INC_ACC, cie_pkg::OP_CLR, cie_pkg::OP_CLR_BIT,
            cie_pkg::OP_MOV_TO_MEM};
        logic [7:0] vals [15] = '{8'h82, 8'h5A, 8'h11, 8'h0F, 8'h00, 8'h30, 8'hFF, 8'h12,
            8'h01, 8'h80, 8'hFF, 8'h7F, 8'hC3, 8'hFF, 8'h99};
        foreach (ops[i])
        begin
            u_mem.mem[{4'(i), 12'hA5C}] = vals[i];
            alu(ops[i], {4'(i), 12'hA5C}, 3'(i), 8'h3C);
        end
        $display("logic test done");
    endtask
    task automatic daa1(input logic [7:0] p, input logic [7:0] q);
        u_mem.mem[16'h2000] = p;
        u_mem.mem[16'h2001] = q;
        alu(cie_pkg::OP_MOV_TO_ACC, 16'h2000, 3'h0, 8'h00);
        alu(cie_pkg::OP_ADD_ACC, 16'h2001, 3'h0, 8'h00);
        alu(cie_pkg::OP_DAA, 16'h3000, 3'h0, 8'h00);
    endtask
    task automatic t_daa;
        daa1(8'h15, 8'h27);
        daa1(8'h99, 8'h99);
        daa1(8'h50, 8'h60);
        $display("decimal adjust test done");
    endtask
    task automatic skip1(input cie_pkg::cie_op_t op, input logic [7:0] m, input logic [2:0] b,
        input logic sk);
        u_mem.mem[16'h7777] = m;
        if (op == cie_pkg::OP_SKIP_ZERO_LOAD)
            e_acc = m;
        issue(op, 16'h7777, b, 8'h00);
        chk({skip, busy, acc, flags}, {sk, sk, e_acc, e_flg});
        @(negedge clk);
        chk({dummy, skip, busy}, {sk, 2'b00});
    endtask
    task automatic t_skip;
        skip1(cie_pkg::OP_SKIP_ZERO_LOAD, 8'h00, 3'h0, 1'b1);
        skip1(cie_pkg::OP_SKIP_ZERO_LOAD, 8'h40, 3'h0, 1'b0);
        skip1(cie_pkg::OP_SKIP_BIT_CLEAR, 8'hF7, 3'h3, 1'b1);
        skip1(cie_pkg::OP_SKIP_BIT_CLEAR, 8'h08, 3'h3, 1'b0);
        skip1(cie_pkg::OP_SKIP_BIT_CLEAR, 8'h7F, 3'h7, 1'b1);
        $display("skip test done");
    endtask
    task automatic tbl1(input cie_pkg::cie_op_t op, input logic last, input logic inc);
        logic [15:0] pa;
        e_tp = e_tp + {7'h00, inc};
        pa = {last ? cie_pkg::LAST_PAGE : 8'h12, e_tp};
        issue(op, 16'hB00B, 3'h0, 8'h00);
        chk({busy, pm_a, tpl}, {1'b1, pa, e_tp});
        @(negedge clk);
        chk({busy, dm_we, dm_a}, {2'b01, 16'hB00B});
        chk({tbh, dm_wd}, {pa[7:0] ^ 8'hA5, pa[15:8] ^ 8'h3C});
        @(negedge clk);
        chk({u_mem.mem[16'hB00B], tph, flags}, {pa[15:8] ^ 8'h3C, 8'h12, e_flg});
    endtask
    task automatic t_table;
        @(negedge clk);
        ptr_lo = 8'hFF;
        ptr_hi = 8'h12;
        ptr_we = 1'b1;
        @(negedge clk);
        ptr_we = 1'b0;
        e_tp = 8'hFF;
        chk({tph, tpl}, 16'h12FF);
        // Low byte at FFh makes the pre-increment wrap without touching the high byte
        tbl1(cie_pkg::OP_TBL_PAGED, 1'b0, 1'b0);
        tbl1(cie_pkg::OP_TBL_LAST, 1'b1, 1'b0);
        tbl1(cie_pkg::OP_TBL_PAGED_INC, 1'b0, 1'b1);
        tbl1(cie_pkg::OP_TBL_LAST_INC, 1'b1, 1'b1);
        $display("table read test done");
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        e_acc = cie_pkg::ACC_RST;
        e_flg = cie_pkg::FLG_RST;
        t_reset();
        t_arith();
        t_logic();
        t_daa();
        t_skip();
        t_table();
        finish_test();
    end
    initial
    begin
        #50us;
        err_count++;
        $display("watchdog expired");
        finish_test();
    end
endmodule // tb_top
